// ### pwif_top.v
// per-port wake event and interrupt flags for ports 1 to 6 of the switch
// assumes one 25 MHz clock, a synchronous active-low reset, phy levels
// arriving asynchronously and frame and filter-rule pulses on clk
//
// Contract
// R1 - wake-frame flag needs destination equal switch address
// R2 - link-up flag set on link up
// R3 - energy flag set on cable energy
// R4 - flags read-only, write clears, upper bits zero
// R5 - enable bit 2 gates wake-frame onto output
// R6 - enable bit 1 gates link-up onto output
// R7 - enable bit 0 gates energy onto output
// R8 - phy status reads pending phy interrupt
// R9 - filter-rule counter interrupt sets status bit 0
// R10 - toggling filter-rule mask bit clears its status
// R11 - mask bits active low, reset to zero
// R12 - power event is OR of enabled flags
// R13 - port request ORs unmasked status bits
//
// The plain strobed port was decided locally.
`default_nettype none
`include "pwif_consts.vh"

module pwif_top #(
   parameter NPORTS = `PWIF_NPORTS,
   parameter [NPORTS-1:0] PHY_PORTS = `PWIF_PHY_PORTS
) (
   input wire clk,
   input wire rst_b,
   input wire [`PWIF_ADDR_W-1:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire reg_wr,
   input wire reg_rd,
   output reg [7:0] reg_rdata,
   input wire wake_frame_valid,
   input wire [2:0] wake_frame_port,
   input wire [47:0] wake_frame_dest,
   input wire [NPORTS-1:0] link_up_pin,
   input wire [NPORTS-1:0] energy_pin,
   input wire [NPORTS-1:0] phy_irq_pin,
   input wire [NPORTS-1:0] filter_rule_irq,
   output reg power_event_output,
   output reg [NPORTS-1:0] port_irq_req,
   output reg irq
);
   // true when the address page selects port number n
   function page_is;
      input [`PWIF_ADDR_W-1:0] addr;
      input [3:0] n;
      begin
         page_is = (addr[`PWIF_PORT_HI:`PWIF_PORT_LO] == n);
      end
   endfunction

   // true when the offset field equals ofs
   function ofs_is;
      input [`PWIF_ADDR_W-1:0] addr;
      input [11:0] ofs;
      begin
         ofs_is = (addr[`PWIF_OFS_HI:`PWIF_OFS_LO] == ofs);
      end
   endfunction

   // true for a write strobe aimed at one page and offset
   function wr_hit;
      input wr;
      input [`PWIF_ADDR_W-1:0] addr;
      input [3:0] n;
      input [11:0] ofs;
      begin
         wr_hit = wr && page_is(addr, n) && ofs_is(addr, ofs);
      end
   endfunction

   wire [NPORTS-1:0] link_level;
   wire [NPORTS-1:0] link_rise;
   wire [NPORTS-1:0] energy_level;
   wire [NPORTS-1:0] energy_rise;
   wire [NPORTS-1:0] phy_irq_level;
   wire [NPORTS-1:0] frame_hit;

   reg [47:0] mac_addr;
   reg [NPORTS*3-1:0] wake_flags;
   reg [NPORTS*3-1:0] wake_en;
   reg [NPORTS-1:0] filter_stat;
   reg [NPORTS*2-1:0] int_mask;
   reg [NPORTS-1:0] girq_stat;
   reg [NPORTS-1:0] girq_en;

   wire [NPORTS-1:0] pme_term;
   wire [NPORTS-1:0] next_req;
   wire [NPORTS*2-1:0] int_stat;
   wire [NPORTS*8-1:0] port_word;
   wire sel_global;

   assign sel_global = page_is(reg_addr, `PWIF_GLOBAL_PAGE);

   pwif_sync #(
      .W(NPORTS)
   ) u_link_sync (
      .clk(clk),
      .rst_b(rst_b),
      .din(link_up_pin),
      .level(link_level),
      .rise(link_rise)
   );

   pwif_sync #(
      .W(NPORTS)
   ) u_energy_sync (
      .clk(clk),
      .rst_b(rst_b),
      .din(energy_pin),
      .level(energy_level),
      .rise(energy_rise)
   );

   pwif_sync #(
      .W(NPORTS)
   ) u_phy_irq_sync (
      .clk(clk),
      .rst_b(rst_b),
      .din(phy_irq_pin),
      .level(phy_irq_level),
      .rise()
   );

   pwif_dest_match #(
      .NPORTS(NPORTS)
   ) u_dest_match (
      .clk(clk),
      .rst_b(rst_b),
      .frame_valid(wake_frame_valid),
      .frame_port(wake_frame_port),
      .frame_dest(wake_frame_dest),
      .mac_addr(mac_addr),
      .hit(frame_hit)
   );

   // switch address bytes, byte 0 is the most significant
   genvar b;
   generate
      for (b = 0; b < 6; b = b + 1) begin : g_mac
         localparam [31:0] MAC_OFS = `PWIF_OFS_MAC0 + b;
         wire mac_wr;

         assign mac_wr = wr_hit(reg_wr, reg_addr, `PWIF_GLOBAL_PAGE, MAC_OFS[11:0]);

         always @(posedge clk) begin
            if (!rst_b) begin
               mac_addr[47-8*b -: 8] <= `PWIF_RESET_BYTE;
            end else if (mac_wr) begin
               mac_addr[47-8*b -: 8] <= reg_wdata;
            end
         end
      end
   endgenerate

   genvar i;
   generate
      for (i = 0; i < NPORTS; i = i + 1) begin : g_port
         wire sel;
         wire wr_flags;
         wire wr_en;
         wire wr_mask;
         wire filter_toggle;
         wire [2:0] wake_set;
         wire [2:0] wake_clr;
         wire [2:0] en_valid;
         wire [1:0] mask_valid;
         reg [7:0] rd_word;
         localparam [31:0] PAGE = i + 1;

         assign sel = page_is(reg_addr, PAGE[3:0]);
         assign wr_flags = wr_hit(reg_wr, reg_addr, PAGE[3:0], `PWIF_OFS_WAKE_FLAGS);
         assign wr_en = wr_hit(reg_wr, reg_addr, PAGE[3:0], `PWIF_OFS_WAKE_EN);
         assign wr_mask = wr_hit(reg_wr, reg_addr, PAGE[3:0], `PWIF_OFS_INT_MASK);

         // link and energy only exist behind an integrated phy
         assign en_valid = PHY_PORTS[i] ? `PWIF_WAKE_ALL : `PWIF_WAKE_MAC_ONLY;
         assign mask_valid = PHY_PORTS[i] ? `PWIF_INT_ALL : `PWIF_INT_MAC_ONLY;

         // a pin already high at reset gives one event soon after release
         assign wake_set[`PWIF_WAKE_FRAME_BIT] = frame_hit[i]; // R1
         assign wake_set[`PWIF_WAKE_LINK_BIT] = link_rise[i] & PHY_PORTS[i]; // R2
         assign wake_set[`PWIF_WAKE_ENERGY_BIT] = energy_rise[i] & PHY_PORTS[i]; // R3
         assign wake_clr = wr_flags ? reg_wdata[2:0] : `PWIF_RESET_WAKE;

         // new event beats a clear in the same cycle
         always @(posedge clk) begin
            if (!rst_b) begin
               wake_flags[3*i +: 3] <= `PWIF_RESET_WAKE;
            end else begin
               wake_flags[3*i +: 3] <= wake_set | (wake_flags[3*i +: 3] & ~wake_clr); // R4
            end
         end

         always @(posedge clk) begin
            if (!rst_b) begin
               wake_en[3*i +: 3] <= `PWIF_RESET_WAKE;
            end else if (wr_en) begin
               wake_en[3*i +: 3] <= reg_wdata[2:0] & en_valid;
            end
         end

         // each flag reaches the output only through its enable
         assign pme_term[i] = |(wake_flags[3*i +: 3] & wake_en[3*i +: 3]); // R5 R6 R7 R12

         // any write that flips mask bit 0 counts as the clearing toggle
         assign filter_toggle = wr_mask && (reg_wdata[`PWIF_INT_FILTER_BIT]
                                != int_mask[2*i + `PWIF_INT_FILTER_BIT]); // R10

         always @(posedge clk) begin
            if (!rst_b) begin
               filter_stat[i] <= 1'b0;
            end else begin
               filter_stat[i] <= filter_rule_irq[i] | (filter_stat[i] & ~filter_toggle); // R9
            end
         end

         // mask bit 1 cannot be set on the mac port, whose phy source is absent
         always @(posedge clk) begin
            if (!rst_b) begin
               int_mask[2*i +: 2] <= `PWIF_RESET_MASK; // R11
            end else if (wr_mask) begin
               int_mask[2*i +: 2] <= reg_wdata[1:0] & mask_valid;
            end
         end

         // phy status follows the pending level, never set on the mac port
         assign int_stat[2*i + `PWIF_INT_PHY_BIT] = phy_irq_level[i] & PHY_PORTS[i]; // R8
         assign int_stat[2*i + `PWIF_INT_FILTER_BIT] = filter_stat[i];

         // mask bit low lets the source through
         assign next_req[i] = |(int_stat[2*i +: 2] & ~int_mask[2*i +: 2]); // R11 R13

         // reserved upper bits stay zero, and so does the word of an unselected port
         always @* begin
            rd_word = 8'h00;
            if (sel) begin
               if (ofs_is(reg_addr, `PWIF_OFS_WAKE_FLAGS)) begin
                  rd_word[2:0] = wake_flags[3*i +: 3]; // R4
               end else if (ofs_is(reg_addr, `PWIF_OFS_WAKE_EN)) begin
                  rd_word[2:0] = wake_en[3*i +: 3];
               end else if (ofs_is(reg_addr, `PWIF_OFS_INT_STAT)) begin
                  rd_word[1:0] = int_stat[2*i +: 2];
               end else if (ofs_is(reg_addr, `PWIF_OFS_INT_MASK)) begin
                  rd_word[1:0] = int_mask[2*i +: 2];
               end
            end
         end

         assign port_word[8*i +: 8] = rd_word;
      end
   endgenerate

   // global sticky summary, one bit per port, write one to clear
   wire girq_wr_stat;
   wire girq_wr_en;

   assign girq_wr_stat = wr_hit(reg_wr, reg_addr, `PWIF_GLOBAL_PAGE, `PWIF_OFS_GIRQ_STAT);
   assign girq_wr_en = wr_hit(reg_wr, reg_addr, `PWIF_GLOBAL_PAGE, `PWIF_OFS_GIRQ_EN);

   // a still-pending request keeps the bit set through a clear in the same cycle
   always @(posedge clk) begin
      if (!rst_b) begin
         girq_stat <= {NPORTS{1'b0}};
      end else if (girq_wr_stat) begin
         girq_stat <= port_irq_req | (girq_stat & ~reg_wdata[NPORTS-1:0]);
      end else begin
         girq_stat <= port_irq_req | girq_stat;
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         girq_en <= {NPORTS{1'b0}};
      end else if (girq_wr_en) begin
         girq_en <= reg_wdata[NPORTS-1:0];
      end
   end

   // registered so the pin holds clean levels between flag updates
   always @(posedge clk) begin
      if (!rst_b) begin
         power_event_output <= 1'b0;
      end else begin
         power_event_output <= |pme_term; // R12
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         port_irq_req <= {NPORTS{1'b0}};
      end else begin
         port_irq_req <= next_req; // R13
      end
   end

   // a new request reaches irq one cycle after it lands in the global status
   always @(posedge clk) begin
      if (!rst_b) begin
         irq <= 1'b0;
      end else begin
         irq <= |(girq_stat & girq_en);
      end
   end

   // read mux; unmapped addresses read zero
   reg [7:0] next_rdata;
   integer p;

   always @* begin
      next_rdata = 8'h00;
      if (sel_global) begin
         if (ofs_is(reg_addr, `PWIF_OFS_GIRQ_STAT)) begin
            next_rdata[NPORTS-1:0] = girq_stat;
         end else if (ofs_is(reg_addr, `PWIF_OFS_GIRQ_EN)) begin
            next_rdata[NPORTS-1:0] = girq_en;
         end
         for (p = 0; p < 6; p = p + 1) begin
            if (ofs_is(reg_addr, `PWIF_OFS_MAC0 + p[11:0])) begin
               next_rdata = mac_addr[47-8*p -: 8];
            end
         end
      end
      // at most one port word is non-zero for any address
      for (p = 0; p < NPORTS; p = p + 1) begin
         next_rdata = next_rdata | port_word[8*p +: 8];
      end
   end

   // data stand only in the cycle after the read strobe
   always @(posedge clk) begin
      if (!rst_b) begin
         reg_rdata <= 8'h00;
      end else if (reg_rd) begin
         reg_rdata <= next_rdata;
      end else begin
         reg_rdata <= 8'h00;
      end
   end
endmodule

`default_nettype wire

// ### pwif_consts.vh
// constants for the port wake and interrupt flag block
// assumes a 16-bit register address: port number in [15:12], offset in [11:0]
`ifndef PWIF_CONSTS_VH
`define PWIF_CONSTS_VH

`define PWIF_NPORTS 6
`define PWIF_PHY_PORTS 6'h1f
`define PWIF_ADDR_W 16
`define PWIF_PORT_HI 15
`define PWIF_PORT_LO 12
`define PWIF_OFS_HI 11
`define PWIF_OFS_LO 0
`define PWIF_FIRST_PORT 4'h1
`define PWIF_GLOBAL_PAGE 4'h0

`define PWIF_OFS_WAKE_FLAGS 12'h013
`define PWIF_OFS_WAKE_EN 12'h017
`define PWIF_OFS_INT_STAT 12'h01b
`define PWIF_OFS_INT_MASK 12'h01f

`define PWIF_OFS_MAC0 12'h302
`define PWIF_OFS_MAC5 12'h307
`define PWIF_OFS_GIRQ_STAT 12'h0f0
`define PWIF_OFS_GIRQ_EN 12'h0f4

`define PWIF_WAKE_FRAME_BIT 2
`define PWIF_WAKE_LINK_BIT 1
`define PWIF_WAKE_ENERGY_BIT 0
`define PWIF_WAKE_W 3
`define PWIF_WAKE_PHY_ONLY 3'h3
`define PWIF_WAKE_ALL 3'h7
`define PWIF_WAKE_MAC_ONLY 3'h4

`define PWIF_INT_PHY_BIT 1
`define PWIF_INT_FILTER_BIT 0
`define PWIF_INT_W 2
`define PWIF_INT_ALL 2'h3
`define PWIF_INT_MAC_ONLY 2'h1

`define PWIF_RESET_WAKE 3'h0
`define PWIF_RESET_MASK 2'h0
`define PWIF_RESET_MAC 48'h000000000000
`define PWIF_RESET_BYTE 8'h00

`endif

// ### pwif_sync.v
// three-stage synchroniser with an agreement filter and a rising-edge pulse
// assumes inputs come from outside the clk domain; one flop set per bit
`default_nettype none

module pwif_sync #(
   parameter W = 6
) (
   input wire clk,
   input wire rst_b,
   input wire [W-1:0] din,
   output reg [W-1:0] level,
   output reg [W-1:0] rise
);
   reg [W-1:0] stage1;
   reg [W-1:0] stage2;
   reg [W-1:0] stage3;
   wire [W-1:0] agree;
   wire [W-1:0] next_level;

   // the first stage feeds only the second
   assign agree = ~(stage2 ^ stage3);
   assign next_level = (agree & stage3) | (~agree & level);

   always @(posedge clk) begin
      if (!rst_b) begin
         stage1 <= {W{1'b0}};
         stage2 <= {W{1'b0}};
         stage3 <= {W{1'b0}};
         level <= {W{1'b0}};
         rise <= {W{1'b0}};
      end else begin
         stage1 <= din;
         stage2 <= stage1;
         stage3 <= stage2;
         level <= next_level;
         rise <= next_level & ~level;
      end
   end
endmodule

`default_nettype wire

// ### pwif_dest_match.v
// compares a received wake frame's destination with the switch address
// assumes frame_valid is a one-cycle pulse from same-clock frame parsing
`default_nettype none

module pwif_dest_match #(
   parameter NPORTS = 6
) (
   input wire clk,
   input wire rst_b,
   input wire frame_valid,
   input wire [2:0] frame_port,
   input wire [47:0] frame_dest,
   input wire [47:0] mac_addr,
   output reg [NPORTS-1:0] hit
);
   integer k;
   reg [NPORTS-1:0] next_hit;

   always @* begin
      next_hit = {NPORTS{1'b0}};
      for (k = 0; k < NPORTS; k = k + 1) begin
         // ports count from one; any other port code is dropped
         if (frame_valid && (frame_dest == mac_addr) && (frame_port == (k[2:0] + 3'h1))) begin
            next_hit[k] = 1'b1; // R1
         end
      end
   end

   always @(posedge clk) begin
      if (!rst_b) begin
         hit <= {NPORTS{1'b0}};
      end else begin
         hit <= next_hit;
      end
   end
endmodule

`default_nettype wire

// ### pwif_checker.sv
// checker for pwif_top: register read framing and output hold relations
// assumes it is bound to pwif_top and sees only its ports
`default_nettype none
module pwif_checker #(
   parameter NPORTS = 6,
   parameter [NPORTS-1:0] PHY_PORTS = 6'h1f
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic [15:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_rdata,
   input wire logic wake_frame_valid,
   input wire logic [2:0] wake_frame_port,
   input wire logic [47:0] wake_frame_dest,
   input wire logic [NPORTS-1:0] link_up_pin,
   input wire logic [NPORTS-1:0] energy_pin,
   input wire logic [NPORTS-1:0] phy_irq_pin,
   input wire logic [NPORTS-1:0] filter_rule_irq,
   input wire logic power_event_output,
   input wire logic [NPORTS-1:0] port_irq_req,
   input wire logic irq
);
   timeunit 1ns;
   timeprecision 1ns;
   logic rd_q;
   logic [15:0] ad_q;
   always @(posedge clk) begin
      rd_q <= reg_rd;
      ad_q <= reg_addr;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   property p_wake_up; rd_q && ad_q[11:0] == 12'h013 |-> reg_rdata[7:3] == 5'h00; endproperty
   property p_en_up; rd_q && ad_q[11:0] == 12'h017 |-> reg_rdata[7:3] == 5'h00; endproperty
   property p_stat_up; rd_q && ad_q[11:0] == 12'h01b |-> reg_rdata[7:2] == 6'h00; endproperty
   property p_mask_up; rd_q && ad_q[11:0] == 12'h01f |-> reg_rdata[7:2] == 6'h00; endproperty
   property p_mac_flag; rd_q && ad_q == 16'h6013 |-> reg_rdata[1:0] == 2'h0; endproperty
   property p_mac_phy; rd_q && ad_q == 16'h601b |-> !reg_rdata[1]; endproperty
   property p_mac_en; rd_q && ad_q == 16'h6017 |-> reg_rdata[1:0] == 2'h0; endproperty
   property p_rd_idle; !rd_q |-> reg_rdata == 8'h00; endproperty
   // a level output may only drop after software wrote something
   property p_pe_hold; $fell(power_event_output) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
   property p_req_fall;
      $fell(port_irq_req[5]) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3);
   endproperty
   property p_req_rise;
      $rose(port_irq_req[5]) |-> $past(filter_rule_irq[5], 2) || $past(reg_wr) || $past(reg_wr, 2);
   endproperty
   a_wake_up: assert property (p_wake_up) else $error("wake flag upper bits set");
   a_en_up: assert property (p_en_up) else $error("enable upper bits set");
   a_stat_up: assert property (p_stat_up) else $error("status upper bits set");
   a_mask_up: assert property (p_mask_up) else $error("mask upper bits set");
   a_mac_flag: assert property (p_mac_flag) else $error("mac port pin flag set");
   a_mac_phy: assert property (p_mac_phy) else $error("mac port phy status set");
   a_mac_en: assert property (p_mac_en) else $error("mac port pin enable set");
   a_rd_idle: assert property (p_rd_idle) else $error("read data outside its cycle");
   a_pe_hold: assert property (p_pe_hold) else $error("power event dropped alone");
   a_req_fall: assert property (p_req_fall) else $error("request dropped alone");
   a_req_rise: assert property (p_req_rise) else $error("request rose alone");
   c_pe: cover property (power_event_output);
   c_irq: cover property ($rose(irq));
   c_wake: cover property ($rose(power_event_output));
   c_filt: cover property (rd_q && ad_q == 16'h601b && reg_rdata[0]);
endmodule
bind pwif_top pwif_checker #(.NPORTS(NPORTS), .PHY_PORTS(PHY_PORTS)) u_chk (
   .clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .wake_frame_valid,
   .wake_frame_port, .wake_frame_dest, .link_up_pin, .energy_pin, .phy_irq_pin,
   .filter_rule_irq, .power_event_output, .port_irq_req, .irq
);
`default_nettype wire

// ### pwif_host_model.sv
// host side model: counts wake notifications and interrupt requests
// assumes registered level outputs on clk
`default_nettype none
module pwif_host_model (
   input wire logic clk,
   input wire logic power_event_output,
   input wire logic irq,
   output var int wake_count,
   output var int irq_count
);
   timeunit 1ns;
   timeprecision 1ns;
   logic pe_q = 1'b0;
   logic irq_q = 1'b0;
   always @(posedge clk) begin
      pe_q <= power_event_output;
      irq_q <= irq;
      if (power_event_output && !pe_q) wake_count <= wake_count + 1;
      if (irq && !irq_q) irq_count <= irq_count + 1;
   end
endmodule
`default_nettype wire

// ### pwif_tb.sv
// self-checking bench for pwif_top: register tasks and scenario sequences
// assumes the host model beside the design and the bound checker
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [15:0] reg_addr = 16'h0000;
   logic [7:0] reg_wdata = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic wake_frame_valid = 1'b0;
   logic [2:0] wake_frame_port = 3'h0;
   logic [47:0] wake_frame_dest = 48'h0;
   logic [5:0] link_up_pin = 6'h00;
   logic [5:0] energy_pin = 6'h00;
   logic [5:0] phy_irq_pin = 6'h00;
   logic [5:0] filter_rule_irq = 6'h00;
   wire [7:0] reg_rdata;
   wire power_event_output;
   wire irq;
   wire [5:0] port_irq_req;
   int wake_count;
   int irq_count;
   int mismatches = 0;
   int comparisons = 0;
   logic [11:0] ofs [4] = '{12'h013, 12'h017, 12'h01b, 12'h01f};
   localparam logic [47:0] mac = 48'h0211_2233_4455;
   always #20 clk = ~clk;
   pwif_top dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .wake_frame_valid, .wake_frame_port, .wake_frame_dest, .link_up_pin, .energy_pin,
      .phy_irq_pin, .filter_rule_irq, .power_event_output, .port_irq_req, .irq);
   pwif_host_model host (.clk, .power_event_output, .irq, .wake_count, .irq_count);
   task automatic test_done;
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input string nm, input logic [15:0] a, input logic [7:0] exp);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 chk(nm, exp, reg_rdata);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic frame(input logic [2:0] p, input logic [47:0] d);
      @(posedge clk);
      wake_frame_valid <= 1'b1;
      wake_frame_port <= p;
      wake_frame_dest <= d;
      @(posedge clk);
      wake_frame_valid <= 1'b0;
   endtask
   initial begin
      repeat (3000) @(posedge clk);
      mismatches++;
      test_done;
   end
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      for (int p = 1; p <= 6; p++) begin
         foreach (ofs[i]) rd("reset", {p[3:0], ofs[i]}, 8'h00);
      end
      wr(16'h1020, 8'hff);
      rd("unmapped", 16'h1020, 8'h00);
      $display("test reset done");
      for (int i = 0; i < 6; i++) wr(16'h0302 + 16'(i), mac[47-8*i -: 8]);
      frame(3'h2, mac ^ 48'h1);
      frame(3'h1, mac);
      cyc(3);
      rd("flags p2", 16'h2013, 8'h00);
      rd("flags p1", 16'h1013, 8'h04);
      chk("pe off", 8'h00, 8'(power_event_output));
      wr(16'h1017, 8'h04);
      rd("en p1", 16'h1017, 8'h04);
      cyc(2);
      chk("pe on", 8'h01, 8'(power_event_output));
      wr(16'h1013, 8'h04);
      rd("flags clr", 16'h1013, 8'h00);
      cyc(2);
      chk("pe clr", 8'h00, 8'(power_event_output));
      wr(16'h1017, 8'h00);
      $display("test wake frame done");
      for (int b = 0; b < 2; b++) begin
         @(posedge clk);
         if (b == 1) link_up_pin[2] <= 1'b1;
         else energy_pin[2] <= 1'b1;
         cyc(8);
         rd("pin flag", 16'h3013, 8'(1 << b));
         chk("pe masked", 8'h00, 8'(power_event_output));
         wr(16'h3017, 8'(1 << b));
         cyc(2);
         chk("pe pin", 8'h01, 8'(power_event_output));
         wr(16'h3013, 8'(1 << b));
         cyc(2);
         chk("pe pin clr", 8'h00, 8'(power_event_output));
         wr(16'h3017, 8'h00);
      end
      @(posedge clk);
      link_up_pin[5] <= 1'b1;
      energy_pin[5] <= 1'b1;
      phy_irq_pin[5] <= 1'b1;
      cyc(8);
      rd("mac flags", 16'h6013, 8'h00);
      rd("mac phy stat", 16'h601b, 8'h00);
      wr(16'h6017, 8'h07);
      rd("mac en", 16'h6017, 8'h04);
      wr(16'h6017, 8'h00);
      $display("test pin events done");
      @(posedge clk);
      phy_irq_pin[0] <= 1'b1;
      cyc(8);
      rd("phy stat", 16'h101b, 8'h02);
      chk("req phy", 8'h01, 8'(port_irq_req[0]));
      wr(16'h101f, 8'h02);
      rd("mask p1", 16'h101f, 8'h02);
      cyc(2);
      chk("req masked", 8'h00, 8'(port_irq_req[0]));
      @(posedge clk);
      phy_irq_pin[0] <= 1'b0;
      wr(16'h00f4, 8'h20);
      @(posedge clk);
      filter_rule_irq[5] <= 1'b1;
      @(posedge clk);
      filter_rule_irq[5] <= 1'b0;
      cyc(4);
      rd("filter stat", 16'h601b, 8'h01);
      chk("req filter", 8'h20, {2'b00, port_irq_req});
      chk("irq", 8'h01, 8'(irq));
      wr(16'h601f, 8'h01);
      rd("filter clr", 16'h601b, 8'h00);
      cyc(2);
      chk("req clr", 8'h00, {2'b00, port_irq_req});
      wr(16'h00f0, 8'h20);
      cyc(2);
      chk("irq clr", 8'h00, 8'(irq));
      wr(16'h601f, 8'h03);
      rd("mac mask", 16'h601f, 8'h01);
      chk("wake seen", 8'h03, 8'(wake_count));
      chk("irq seen", 8'h01, 8'(irq_count));
      $display("test interrupts done");
      test_done;
   end
endmodule
`default_nettype wire
